/* shared/dsl_framer_defs.svh */
`ifndef DSL_FRAMER_DEFS_SVH
`define DSL_FRAMER_DEFS_SVH
`define A_TX_EOC      8'h80
`define A_TX_IND      8'h81
`define A_TX_SIG_IN   8'h82
`define A_TX_SYNC_LO  8'h83
`define A_TX_SYNC_HI  8'h84
`define A_TX_SIG_OUT  8'h85
`define A_TX_CMD1     8'h86
`define A_TX_CMD2     8'h87
`define A_TX_CRC      8'h88
`define A_RX_CMD2     8'h91
`define A_CMD1        8'hC0
`define A_RX_EOC      8'hE0
`define A_RX_IND      8'hE2
`define A_RX_SIG      8'hE4
`define A_PCM_FMT     8'hF1
`define B_WHITEN      0
`define B_INJECT      1
`define B_POLY        2
`define B_LOOP_LF     3
`define B_LOOP_CF     6
`define B_LOOP_CN     2
`define B_LOOP_LN     3
`define B_COMPRESS    5
`define B_ENC_SYNC    6
`define SYNC_BITS     14
`define CRC_BITS      6
`define OH_BITS       24
`define CRC_POLY      6'h03
`define TAP_CO        4
`define TAP_RT        17
`define SIG_TICK_US   1000
`define MCLK_MHZ      25
`define SIG_PER_01    3'h3
`define SIG_PER_10    3'h2
`define SIG_PER_11    3'h1
`define MAX_SYNC_LINES 18
`define Q_NEG3        3'h5
`define Q_NEG1        3'h7
`define Q_POS1        3'h1
`define Q_POS3        3'h3
`endif

/* shared/dsl_framer_pkg.sv */
package dsl_framer_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic [7:0] eoc;
      logic [7:0] status_flag_bits;
      logic [7:0] sig;
   } rx_oh_t;
   typedef struct packed {
      logic [7:0]  eoc;
      logic [7:0]  status_flag_bits;
      logic [7:0]  sig;
      logic [13:0] sync;
   } tx_oh_t;
   typedef struct packed {
      logic       compress;
      logic       enc_sync;
      logic [4:0] slots;
   } pcm_cfg_t;
endpackage

/* core/line_quat_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsl_framer_defs.svh"
module line_quat_encoder (
   // Link clock and reset.
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   // Serial bit stream, first bit of a pair flagged.
   input  wire logic       bit_in,
   input  wire logic       valid_in,
   input  wire logic       first_in,
   // Line outputs.
   output logic            serial_out,
   output logic [2:0]      symbol_out
);
   typedef struct packed {
      logic       serial;
      logic       sign;
      logic [2:0] symbol;
   } enc_state_t;
   enc_state_t q, d;
   always_comb begin
      d = q;
      if (valid_in) begin
         d.serial = bit_in;
         if (first_in) begin
            d.sign = bit_in;
         end else begin
            unique case ({q.sign, bit_in})
               2'b00: d.symbol = `Q_NEG3;
               2'b01: d.symbol = `Q_NEG1;
               2'b11: d.symbol = `Q_POS1;
               2'b10: d.symbol = `Q_POS3;
            endcase
         end
      end
      if (!rstn_in) begin
         d = '0;
      end
   end
   always_ff @(posedge clk_in) begin
      q <= d;
   end
   assign serial_out = q.serial;
   assign symbol_out = q.symbol;
endmodule
`default_nettype wire

/* core/pcm_formatter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsl_framer_defs.svh"
module pcm_formatter import dsl_framer_pkg::*; #(
   parameter int unsigned FRAME_CLKS = 256
) (
   // System clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // Codec pins.
   input  wire logic        codec_clock_in,
   input  wire logic        codec_tx_serial_in,
   output logic             codec_rx_serial_out,
   output logic [17:0]      codec_frame_sync_out,
   // Control.
   input  wire pcm_cfg_t    cfg_in,
   input  wire logic        loop_codec_near_in,
   input  wire logic        loop_line_near_in,
   // Payload toward and from the line path.
   input  wire logic        rx_bit_in,
   output logic             rx_take_out,
   output logic             tx_bit_out,
   output logic             tx_strobe_out
);
   typedef struct packed {
      logic        k1, k2, k3, d1, d2;
      logic [7:0]  idx;
      logic        rxb, take, txb, txs, last_tx;
      logic [17:0] fs;
   } fmt_state_t;
   fmt_state_t q, d;
   logic [5:0] chan;
   logic [5:0] limit;
   always_comb begin
      d = q;
      d.k1 = codec_clock_in;
      d.k2 = q.k1;
      d.k3 = q.k2;
      d.d1 = codec_tx_serial_in;
      d.d2 = q.d1;
      d.take = 1'b0;
      d.txs = 1'b0;
      chan = cfg_in.compress ? q.idx[7:2] : {1'b0, q.idx[7:3]};
      limit = cfg_in.compress ? {cfg_in.slots, 1'b0} : {1'b0, cfg_in.slots};
      if (q.k2 && !q.k3) begin
         d.idx = (q.idx == 8'(FRAME_CLKS - 1)) ? 8'h00 : q.idx + 8'h01;
         d.rxb = loop_codec_near_in ? q.last_tx : rx_bit_in;
         d.take = 1'b1;
         d.fs = 18'h00000;
         if (chan < limit) begin
            if (cfg_in.enc_sync) begin
               d.fs = {12'h000, chan + 6'h01};
            end else if (chan < 6'(`MAX_SYNC_LINES)) begin
               d.fs = 18'h00001 << chan;
            end
         end
      end
      if (!q.k2 && q.k3) begin
         d.last_tx = q.d2;
         d.txb = loop_line_near_in ? rx_bit_in : q.d2;
         d.txs = 1'b1;
      end
      if (!rstn_in) begin
         d = '0;
      end
   end
   always_ff @(posedge clk_in) begin
      q <= d;
   end
   assign codec_rx_serial_out = q.rxb;
   assign codec_frame_sync_out = q.fs;
   assign rx_take_out = q.take;
   assign tx_bit_out = q.txb;
   assign tx_strobe_out = q.txs;
endmodule
`default_nettype wire

/* core/dsl_pcm_overhead_framer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsl_framer_defs.svh"
module dsl_pcm_overhead_framer import dsl_framer_pkg::*; #(
   parameter int unsigned MS_CYCLES      = `SIG_TICK_US * `MCLK_MHZ,
   parameter int unsigned FRAME_BITS     = 576,
   parameter int unsigned PCM_FRAME_CLKS = 256,
   parameter logic [13:0] SYNC_RESET     = 14'h0000
) (
   // System clock and reset.
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   // Microcomputer register port.
   input  wire reg_req_t    reg_req_in,
   output logic [7:0]       reg_rdata_out,
   output logic             load_signaling_event_out,
   // Overhead from the receive framer.
   input  wire logic        rx_frame_pulse_in,
   input  wire rx_oh_t      rx_oh_in,
   // DSL link side, on the line clock.
   input  wire logic        line_clk_in,
   input  wire logic        quat_phase_clock_in,
   input  wire logic        rx_line_serial_in,
   input  wire logic        payload_bit_in,
   output logic             payload_take_out,
   output logic             tx_line_serial_out,
   output logic [2:0]       tx_quat_symbol_out,
   output logic             rx_line_to_framer_out,
   // PCM codec side.
   input  wire logic        codec_clock_in,
   input  wire logic        codec_tx_serial_in,
   output logic             codec_rx_serial_out,
   output logic [17:0]      codec_frame_sync_out,
   input  wire logic        pcm_rx_bit_in,
   output logic             pcm_rx_take_out,
   output logic             pcm_tx_bit_out,
   output logic             pcm_tx_strobe_out
);
   localparam int unsigned CRC_END = `SYNC_BITS + `CRC_BITS;
   localparam int unsigned OH_END  = CRC_END + `OH_BITS;

   typedef struct packed {
      tx_oh_t      oh;
      logic [7:0]  sig_out;
      logic [7:0]  tx_cmd1;
      logic [7:0]  tx_cmd2;
      logic [7:0]  rx_cmd2;
      logic [7:0]  cmd1;
      logic [7:0]  pcm_fmt;
      rx_oh_t      rx_rd;
      logic [7:0]  rdata;
      logic [15:0] ms_cnt;
      logic [2:0]  sub_cnt;
      logic        lse;
      logic        xtog;
      tx_oh_t      xfer;
      logic        ct1, ct2, ct3;
      logic [5:0]  crc_rd;
   } mc_state_t;

   typedef struct packed {
      logic        rs1, rs2;
      logic        t1, t2, t3;
      logic [4:0]  c1, c2;
      logic        qp1, qp2;
      logic        rl1, rl2;
      tx_oh_t      stage;
      tx_oh_t      oh;
      logic        started;
      logic [15:0] cnt;
      logic [5:0]  crc;
      logic [5:0]  crc_prev;
      logic        inj;
      logic [22:0] scr;
      logic        ctog;
      logic        rxo;
   } lk_state_t;

   mc_state_t mq, md;
   lk_state_t lq, ld;

   // Level copies of the link-facing control bits, gathered in the system domain.
   logic [4:0]  link_cfg;
   logic        ms_tick;
   logic [2:0]  sig_period;
   logic        sig_event;
   logic        wr_hit;
   pcm_cfg_t    pcm_cfg;

   // Link domain combinational terms.
   logic        sync_pos;
   logic        feed;
   logic        take;
   logic        data;
   logic        tx_bit;
   logic        fb;
   logic        whiten;
   logic        tap_bit;
   logic        line_bit;
   logic [15:0] pos;
   logic [23:0] ohv;
   logic [15:0] ofs;

   assign link_cfg = {mq.rx_cmd2[`B_LOOP_CF], mq.tx_cmd2[`B_LOOP_LF], mq.tx_cmd2[`B_POLY],
                      mq.tx_cmd1[`B_INJECT], mq.tx_cmd1[`B_WHITEN]};
   assign pcm_cfg = '{compress: mq.pcm_fmt[`B_COMPRESS], enc_sync: mq.pcm_fmt[`B_ENC_SYNC],
                      slots: mq.pcm_fmt[4:0]};

   // System-domain side: registers, load-signaling timer and the crossings.
   always_comb begin
      md = mq;
      wr_hit = reg_req_in.wr;
      ms_tick = (mq.ms_cnt == 16'(MS_CYCLES - 1));
      md.ms_cnt = ms_tick ? 16'h0000 : mq.ms_cnt + 16'h0001;
      unique case (mq.cmd1[1:0])
         2'b00: sig_period = 3'h0;
         2'b01: sig_period = `SIG_PER_01;
         2'b10: sig_period = `SIG_PER_10;
         2'b11: sig_period = `SIG_PER_11;
      endcase
      sig_event = rx_frame_pulse_in;
      if (rx_frame_pulse_in) begin
         md.sub_cnt = 3'h0;
         md.ms_cnt = 16'h0000;
      end else if (ms_tick && sig_period != 3'h0) begin
         // A rate change can leave the count past the new end; it fires on the next ms tick.
         if (mq.sub_cnt >= sig_period - 3'h1) begin
            sig_event = 1'b1;
            md.sub_cnt = 3'h0;
         end else begin
            md.sub_cnt = mq.sub_cnt + 3'h1;
         end
      end
      md.lse = sig_event;
      // The receive side writes the readable copies only on frame and signaling events.
      if (rx_frame_pulse_in) begin
         md.rx_rd.eoc = rx_oh_in.eoc;
         md.rx_rd.status_flag_bits = rx_oh_in.status_flag_bits;
      end
      if (sig_event) begin
         md.rx_rd.sig = rx_oh_in.sig;
         md.sig_out = mq.oh.sig;
         md.xfer = '{eoc: mq.oh.eoc, status_flag_bits: mq.oh.status_flag_bits, sig: mq.oh.sig, sync: mq.oh.sync};
         md.xtog = ~mq.xtog;
      end
      if (wr_hit) begin
         unique case (reg_req_in.addr)
            `A_TX_EOC:     md.oh.eoc = reg_req_in.wdata;
            `A_TX_IND:     md.oh.status_flag_bits = reg_req_in.wdata;
            `A_TX_SIG_IN:  md.oh.sig = reg_req_in.wdata;
            `A_TX_SYNC_LO: md.oh.sync[7:0] = reg_req_in.wdata;
            `A_TX_SYNC_HI: md.oh.sync[13:8] = reg_req_in.wdata[5:0];
            `A_TX_CMD1:    md.tx_cmd1 = reg_req_in.wdata;
            `A_TX_CMD2:    md.tx_cmd2 = reg_req_in.wdata;
            `A_RX_CMD2:    md.rx_cmd2 = reg_req_in.wdata;
            `A_CMD1:       md.cmd1 = reg_req_in.wdata;
            `A_PCM_FMT:    md.pcm_fmt = reg_req_in.wdata;
            default:       md.cmd1 = mq.cmd1;
         endcase
      end
      // Check bits come over by a toggle; they hold for a whole line frame.
      md.ct1 = lq.ctog;
      md.ct2 = mq.ct1;
      md.ct3 = mq.ct2;
      if (mq.ct2 != mq.ct3) begin
         md.crc_rd = lq.crc_prev;
      end
      if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            `A_TX_EOC:     md.rdata = mq.oh.eoc;
            `A_TX_IND:     md.rdata = mq.oh.status_flag_bits;
            `A_TX_SIG_IN:  md.rdata = mq.oh.sig;
            `A_TX_SYNC_LO: md.rdata = mq.oh.sync[7:0];
            `A_TX_SYNC_HI: md.rdata = {2'h0, mq.oh.sync[13:8]};
            `A_TX_SIG_OUT: md.rdata = mq.sig_out;
            `A_TX_CRC:     md.rdata = {2'h0, mq.crc_rd};
            `A_TX_CMD1:    md.rdata = mq.tx_cmd1;
            `A_TX_CMD2:    md.rdata = mq.tx_cmd2;
            `A_RX_CMD2:    md.rdata = mq.rx_cmd2;
            `A_CMD1:       md.rdata = mq.cmd1;
            `A_PCM_FMT:    md.rdata = mq.pcm_fmt;
            `A_RX_EOC:     md.rdata = mq.rx_rd.eoc;
            `A_RX_IND:     md.rdata = mq.rx_rd.status_flag_bits;
            `A_RX_SIG:     md.rdata = mq.rx_rd.sig;
            default:       md.rdata = 8'h00;
         endcase
      end
      if (!resetn_in) begin
         md = '0;
         md.oh.sync = SYNC_RESET;
      end
   end

   always_ff @(posedge mclk_in) begin
      mq <= md;
   end

   // Line-clock side: frame builder, check bits and whitener.
   always_comb begin
      ld = lq;
      ld.rs1 = resetn_in;
      ld.rs2 = lq.rs1;
      ld.t1 = mq.xtog;
      ld.t2 = lq.t1;
      ld.t3 = lq.t2;
      ld.c1 = link_cfg;
      ld.c2 = lq.c1;
      ld.qp1 = quat_phase_clock_in;
      ld.qp2 = lq.qp1;
      ld.rl1 = rx_line_serial_in;
      ld.rl2 = lq.rl1;
      if (lq.t2 != lq.t3) begin
         ld.stage = mq.xfer;
      end
      pos = lq.cnt;
      ohv = {lq.oh.eoc, lq.oh.status_flag_bits, lq.oh.sig};
      ofs = 16'h0000;
      sync_pos = 1'b0;
      feed = 1'b0;
      take = 1'b0;
      if (pos < 16'(`SYNC_BITS)) begin
         sync_pos = 1'b1;
         data = lq.oh.sync[4'(`SYNC_BITS - 1 - pos)];
      end else if (pos < 16'(CRC_END)) begin
         ofs = pos - 16'(`SYNC_BITS);
         data = lq.crc_prev[3'(`CRC_BITS - 1 - ofs)] ^ lq.inj;
      end else if (pos < 16'(OH_END)) begin
         ofs = pos - 16'(CRC_END);
         data = ohv[5'(`OH_BITS - 1 - ofs)];
         feed = 1'b1;
      end else begin
         data = payload_bit_in;
         feed = 1'b1;
         take = 1'b1;
      end
      whiten = lq.c2[`B_WHITEN];
      tap_bit = lq.c2[`B_POLY] ? lq.scr[`TAP_RT] : lq.scr[`TAP_CO];
      tx_bit = (whiten && !sync_pos) ? (data ^ tap_bit ^ lq.scr[22]) : data;
      fb = lq.crc[5] ^ data;
      line_bit = lq.c2[`B_LOOP_LF] ? lq.rl2 : tx_bit;
      ld.rxo = lq.c2[4] ? line_bit : lq.rl2;
      if (!lq.started) begin
         ld.started = lq.qp2;
         ld.cnt = 16'h0000;
      end else begin
         if (!sync_pos) begin
            ld.scr = {lq.scr[21:0], tx_bit};
         end
         if (feed) begin
            ld.crc = {lq.crc[4:0], 1'b0} ^ (fb ? `CRC_POLY : 6'h00);
         end
         if (pos == 16'(FRAME_BITS - 1)) begin
            ld.cnt = 16'h0000;
            ld.crc_prev = ld.crc;
            ld.crc = 6'h00;
            ld.inj = lq.c2[`B_INJECT];
            ld.oh = lq.stage;
            ld.ctog = ~lq.ctog;
         end else begin
            ld.cnt = lq.cnt + 16'h0001;
         end
      end
      if (!lq.rs2) begin
         ld = '0;
         ld.rs1 = resetn_in;
         ld.rs2 = lq.rs1;
      end
   end

   always_ff @(posedge line_clk_in) begin
      lq <= ld;
   end

   line_quat_encoder u_enc (
      .clk_in     (line_clk_in),
      .rstn_in    (lq.rs2),
      .bit_in     (line_bit),
      .valid_in   (lq.started),
      .first_in   (~lq.cnt[0]),
      .serial_out (tx_line_serial_out),
      .symbol_out (tx_quat_symbol_out)
   );

   pcm_formatter #(
      .FRAME_CLKS (PCM_FRAME_CLKS)
   ) u_pcm (
      .clk_in               (mclk_in),
      .rstn_in              (resetn_in),
      .codec_clock_in       (codec_clock_in),
      .codec_tx_serial_in   (codec_tx_serial_in),
      .codec_rx_serial_out  (codec_rx_serial_out),
      .codec_frame_sync_out (codec_frame_sync_out),
      .cfg_in               (pcm_cfg),
      .loop_codec_near_in   (mq.cmd1[`B_LOOP_CN]),
      .loop_line_near_in    (mq.cmd1[`B_LOOP_LN]),
      .rx_bit_in            (pcm_rx_bit_in),
      .rx_take_out          (pcm_rx_take_out),
      .tx_bit_out           (pcm_tx_bit_out),
      .tx_strobe_out        (pcm_tx_strobe_out)
   );

   assign payload_take_out = lq.started & take;
   assign rx_line_to_framer_out = lq.rxo;
   assign reg_rdata_out = mq.rdata;
   assign load_signaling_event_out = mq.lse;
endmodule
`default_nettype wire

/* tb/framer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module framer_sva import dsl_framer_pkg::*; (
   // Clock and reset.
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   // Watched ports.
   input  wire reg_req_t    reg_req_in,
   input  wire logic [7:0]  reg_rdata_out,
   input  wire logic        load_signaling_event_out,
   input  wire logic        rx_frame_pulse_in,
   input  wire logic [2:0]  tx_quat_symbol_out,
   input  wire logic [17:0] codec_frame_sync_out,
   input  wire logic        pcm_rx_take_out
);
   // Syncs are judged only once the format has stood long enough to flush old slots.
   logic [7:0] rate_q;
   logic [7:0] fmt_q;
   logic [7:0] age_q;
   logic [7:0] run_q;
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rate_q <= 8'h00;
         fmt_q <= 8'h00;
         age_q <= 8'h00;
      end else begin
         if (reg_req_in.wr && reg_req_in.addr == 8'hC0) rate_q <= reg_req_in.wdata;
         if (reg_req_in.wr && reg_req_in.addr == 8'hF1) begin
            fmt_q <= reg_req_in.wdata;
            age_q <= 8'h01;
         end else if (age_q != 8'h00 && age_q != 8'hFF) begin
            age_q <= age_q + 8'h01;
         end
      end
      run_q <= codec_frame_sync_out[0] ? run_q + 8'h01 : 8'h00;
   end
   property p_unmapped;
      @(posedge mclk_in) disable iff (!resetn_in)
      reg_req_in.rd && !reg_req_in.addr[7] |=> reg_rdata_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_hold;
      @(posedge mclk_in) disable iff (!resetn_in) !reg_req_in.rd |=> $stable(reg_rdata_out);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_frame_evt;
      @(posedge mclk_in) disable iff (!resetn_in) rx_frame_pulse_in |=> load_signaling_event_out;
   endproperty
   a_frame_evt: assert property (p_frame_evt) else $error("no event after frame");
   property p_quiet;
      @(posedge mclk_in) disable iff (!resetn_in)
      !rx_frame_pulse_in && rate_q[1:0] == 2'b00 |=> !load_signaling_event_out;
   endproperty
   a_quiet: assert property (p_quiet) else $error("extra event at default rate");
   property p_symbol;
      @(posedge mclk_in) disable iff (!resetn_in)
      tx_quat_symbol_out != 3'h0 |-> tx_quat_symbol_out inside {3'h1, 3'h3, 3'h5, 3'h7};
   endproperty
   a_symbol: assert property (p_symbol) else $error("illegal line symbol");
   property p_coded;
      @(posedge mclk_in) disable iff (!resetn_in)
      fmt_q[6] && age_q == 8'hFF |-> codec_frame_sync_out[17:6] == 12'h000;
   endproperty
   a_coded: assert property (p_coded) else $error("upper syncs active in coded mode");
   property p_unused;
      @(posedge mclk_in) disable iff (!resetn_in)
      fmt_q[6:5] == 2'b00 && age_q == 8'hFF |-> (codec_frame_sync_out >> fmt_q[4:0]) == 18'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused slot sync active");
   property p_period;
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(codec_frame_sync_out[0]) && age_q == 8'hFF |-> run_q == (fmt_q[5] ? 8'h30 : 8'h60);
   endproperty
   a_period: assert property (p_period) else $error("sync width wrong");
   property p_take;
      @(posedge mclk_in) disable iff (!resetn_in) pcm_rx_take_out |=> !pcm_rx_take_out;
   endproperty
   a_take: assert property (p_take) else $error("codec take longer than a cycle");
endmodule
bind dsl_pcm_overhead_framer framer_sva u_sva (.mclk_in, .resetn_in, .reg_req_in,
   .reg_rdata_out, .load_signaling_event_out, .rx_frame_pulse_in, .tx_quat_symbol_out,
   .codec_frame_sync_out, .pcm_rx_take_out);
`default_nettype wire

/* tb/dsl_line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module dsl_line_partner (
   // Reset and requests.
   input  wire logic resetn_in,
   input  wire logic payload_take_in,
   input  wire logic codec_level_in,
   // Line side.
   output logic      line_clk_out,
   output logic      quat_phase_clock_out,
   output logic      rx_line_serial_out,
   output logic      payload_bit_out,
   // Codec side.
   output logic      codec_clock_out,
   output logic      codec_tx_serial_out
);
   initial begin
      quat_phase_clock_out = 1'b0;
      rx_line_serial_out = 1'b0;
      payload_bit_out = 1'b0;
      codec_tx_serial_out = 1'b0;
   end
   // Odd offsets keep both clocks clear of the system clock edges.
   initial begin
      line_clk_out = 1'b0;
      #13;
      forever #40 line_clk_out = ~line_clk_out;
   end
   initial begin
      codec_clock_out = 1'b0;
      #7;
      forever #240 codec_clock_out = ~codec_clock_out;
   end
   always @(posedge line_clk_out) begin
      quat_phase_clock_out <= ~quat_phase_clock_out;
      rx_line_serial_out <= ~rx_line_serial_out;
      if (!resetn_in) payload_bit_out <= 1'b0;
      else if (payload_take_in) payload_bit_out <= ~payload_bit_out;
   end
   // The codec launches on rising so the framer can sample on falling.
   always @(posedge codec_clock_out) codec_tx_serial_out <= codec_level_in;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsl_framer_defs.svh"
module tb_top import dsl_framer_pkg::*; ;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   reg_req_t    req = '0;
   rx_oh_t      rx_oh = '0;
   logic        pulse = 1'b0;
   logic        pcm_rx_bit = 1'b0;
   logic        level = 1'b0;
   logic        line_clk, quat, rx_line, pay_bit, pay_take, codec_clk, codec_tx;
   logic        tx_ser, evt, codec_rx, pcm_tx_bit;
   logic [7:0]  rdata;
   logic [17:0] syncs;
   logic [43:0] hist = '0;
   logic [43:0] snap = '0;
   logic        take_q = 1'b0;
   int          snap_n = 0;
   int          error_cnt = 0;
   int          n_compared = 0;
   always #20 mclk = ~mclk;
   dsl_line_partner u_partner (.resetn_in(resetn), .payload_take_in(pay_take),
      .codec_level_in(level), .line_clk_out(line_clk), .quat_phase_clock_out(quat),
      .rx_line_serial_out(rx_line), .payload_bit_out(pay_bit),
      .codec_clock_out(codec_clk), .codec_tx_serial_out(codec_tx));
   dsl_pcm_overhead_framer #(.MS_CYCLES(50), .FRAME_BITS(64), .PCM_FRAME_CLKS(64)) u_dut (
      .mclk_in(mclk), .resetn_in(resetn), .reg_req_in(req), .reg_rdata_out(rdata),
      .load_signaling_event_out(evt), .rx_frame_pulse_in(pulse), .rx_oh_in(rx_oh),
      .line_clk_in(line_clk), .quat_phase_clock_in(quat), .rx_line_serial_in(rx_line),
      .payload_bit_in(pay_bit), .payload_take_out(pay_take), .tx_line_serial_out(tx_ser),
      .tx_quat_symbol_out(), .rx_line_to_framer_out(), .codec_clock_in(codec_clk),
      .codec_tx_serial_in(codec_tx), .codec_rx_serial_out(codec_rx),
      .codec_frame_sync_out(syncs), .pcm_rx_bit_in(pcm_rx_bit), .pcm_rx_take_out(),
      .pcm_tx_bit_out(pcm_tx_bit), .pcm_tx_strobe_out());
   // Payload starts right after the overhead, so a snapshot holds frame bits 0 to 43.
   always @(posedge line_clk) begin
      hist <= {hist[42:0], tx_ser};
      take_q <= pay_take;
      if (pay_take && !take_q) begin
         snap <= {hist[42:0], tx_ser};
         snap_n <= snap_n + 1;
      end
   end
   function automatic logic [5:0] crc_of(input logic [23:0] oh);
      logic [43:0] m;
      logic [5:0]  r;
      m = {oh, {10{2'b01}}};
      r = 6'h00;
      for (int i = 43; i >= 0; i--) r = {r[4:0], 1'b0} ^ ((m[i] ^ r[5]) ? `CRC_POLY : 6'h00);
      return r;
   endfunction
   function automatic logic [6:0] unwhite(input logic [43:0] s, input int t);
      logic [6:0] r;
      for (int j = 0; j < 7; j++) r[j] = s[j] ^ s[j + t] ^ s[j + 23];
      return r;
   endfunction
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang();
      check(24'h0, 24'h1);
      stop_test();
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      req <= '0;
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk);
      req <= '0;
      #1;
      check({16'h0, rdata}, {16'h0, e});
   endtask
   task automatic frame_evt();
      @(posedge mclk);
      pulse <= 1'b1;
      @(posedge mclk);
      pulse <= 1'b0;
   endtask
   task automatic wait_frames(input int k);
      int n0;
      n0 = snap_n;
      for (int i = 0; i < 600 * k; i++) begin
         @(posedge mclk);
         if (snap_n >= n0 + k) return;
      end
      hang();
   endtask
   task automatic wait_evt(output int n);
      n = 0;
      for (int i = 0; i < 400; i++) begin
         @(posedge mclk);
         #1;
         n++;
         if (evt === 1'b1) return;
      end
      hang();
   endtask
   task automatic test_regs();
      logic [7:0] a[5] = '{8'h86, 8'h87, 8'h91, 8'hC0, 8'hF1};
      for (int i = 0; i < 5; i++) begin
         reg_wr(a[i], 8'h5A);
         rd_check(a[i], 8'h5A);
         reg_wr(a[i], 8'h00);
      end
      rd_check(8'h10, 8'h00);
      $display("test_regs done");
   endtask
   task automatic test_signaling();
      rx_oh <= '{8'h11, 8'h22, 8'h33};
      reg_wr(8'h82, 8'hC5);
      frame_evt();
      rd_check(8'h85, 8'hC5);
      rd_check(8'hE0, 8'h11);
      rd_check(8'hE2, 8'h22);
      rd_check(8'hE4, 8'h33);
      reg_wr(8'hE0, 8'hFF);
      rd_check(8'hE0, 8'h11);
      reg_wr(8'h82, 8'hA7);
      rd_check(8'h85, 8'hC5);
      $display("test_signaling done");
   endtask
   task automatic test_rate();
      int exp_gap[3] = '{150, 100, 50};
      int gap;
      for (int i = 0; i < 3; i++) begin
         reg_wr(8'hC0, 8'(i + 1));
         wait_evt(gap);
         wait_evt(gap);
         check(24'(gap), 24'(exp_gap[i]));
      end
      reg_wr(8'hC0, 8'h00);
      $display("test_rate done");
   endtask
   task automatic test_line();
      logic [5:0]  c;
      logic [43:0] s0;
      reg_wr(8'h83, 8'h5B);
      reg_wr(8'h84, 8'h2A);
      reg_wr(8'h80, 8'h96);
      reg_wr(8'h81, 8'h3C);
      frame_evt();
      wait_frames(3);
      c = crc_of(snap[23:0]);
      check({10'h0, snap[43:30]}, 24'h002A5B);
      check(snap[23:0], 24'h963CA7);
      check({18'h0, snap[29:24]}, {18'h0, c});
      rd_check(8'h88, {2'b00, c});
      reg_wr(8'h86, 8'h02);
      wait_frames(3);
      check({18'h0, snap[29:24]}, {18'h0, ~c});
      reg_wr(8'h86, 8'h01);
      wait_frames(3);
      s0 = snap;
      check({10'h0, s0[43:30]}, 24'h002A5B);
      check({23'h0, s0[29:0] !== {c, 24'h963CA7}}, 24'h000001);
      check({17'h0, unwhite(s0, 5)}, 24'h000027);
      reg_wr(8'h87, 8'h04);
      wait_frames(3);
      check({17'h0, unwhite(snap, 18)}, 24'h000027);
      reg_wr(8'h87, 8'h08);
      wait_frames(2);
      check({23'h0, snap == {22{snap[1:0]}} && snap[1] != snap[0]}, 24'h000001);
      reg_wr(8'h86, 8'h00);
      reg_wr(8'h87, 8'h00);
      $display("test_line done");
   endtask
   task automatic test_pcm();
      logic [7:0]  f[3] = '{8'h02, 8'h22, 8'h42};
      logic [23:0] e[3] = '{24'h3, 24'hF, 24'h3};
      logic [17:0] acc;
      for (int i = 0; i < 3; i++) begin
         reg_wr(8'hF1, f[i]);
         repeat (300) @(posedge mclk);
         acc = '0;
         repeat (800) begin
            @(posedge mclk);
            #1;
            acc |= syncs;
         end
         check({6'h0, acc}, e[i]);
      end
      $display("test_pcm done");
   endtask
   task automatic test_loop();
      reg_wr(8'hC0, 8'h04);
      for (int i = 0; i < 2; i++) begin
         level <= i[0];
         pcm_rx_bit <= ~i[0];
         repeat (60) @(posedge mclk);
         #1;
         check({23'h0, codec_rx}, {23'h0, i[0]});
         check({23'h0, pcm_tx_bit}, {23'h0, i[0]});
      end
      reg_wr(8'hC0, 8'h00);
      repeat (60) @(posedge mclk);
      #1;
      check({23'h0, codec_rx}, 24'h0);
      reg_wr(8'hC0, 8'h08);
      level <= 1'b0;
      pcm_rx_bit <= 1'b1;
      repeat (60) @(posedge mclk);
      #1;
      check({23'h0, pcm_tx_bit}, 24'h000001);
      check({23'h0, codec_rx}, 24'h000001);
      $display("test_loop done");
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      test_regs();
      test_signaling();
      test_rate();
      test_line();
      test_pcm();
      test_loop();
      stop_test();
   end
endmodule
`default_nettype wire
